// >>> ulp_pkg.sv
// What this block does
// - sleep stops every port clock, held low
// - sleep abandons the character being sent
// - serial output held high during sleep
// - sleep abandons the character being received
// - sleep leaves registers and buffers unchanged
// - armed wake: falling input edge raises rx flag
// - wake flag ignores the rx interrupt selection
// - wake leaves sleep only if rx enabled
// - wake event needs the global port enable
// - idle: run if halt bit 0, stop if 1
// - unimplemented register bits read as zero
// - baud is clock over 16 times (divisor+1)
// - rx fifo cleared by reset, kept through sleep
package ulp_pkg;
  localparam int NPORT = 2;
  localparam int RX_DEPTH = 4;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_P1_MODE = 10'h20c;
  localparam logic [9:0] IDX_P1_STA = 10'h20e;
  localparam logic [9:0] IDX_P1_TX = 10'h210;
  localparam logic [9:0] IDX_P1_RX = 10'h212;
  localparam logic [9:0] IDX_P1_BRG = 10'h214;
  localparam logic [9:0] IDX_P2_MODE = 10'h216;
  localparam logic [9:0] IDX_P2_STA = 10'h218;
  localparam logic [9:0] IDX_P2_TX = 10'h21a;
  localparam logic [9:0] IDX_P2_RX = 10'h21c;
  localparam logic [9:0] IDX_P2_BRG = 10'h21e;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h220;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h222;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h224;
  // mode register fields
  localparam int MODE_EN_BIT = 15;
  localparam int MODE_HALT_BIT = 13;
  localparam int MODE_WAKE_BIT = 7;
  localparam int MODE_LOOP_BIT = 6;
  localparam logic [15:0] MODE_WR_MASK = 16'ha0c0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  // status register fields
  localparam int STA_TXEN_BIT = 10;
  localparam int STA_TXBF_BIT = 9;
  localparam int STA_SHIFTER_EMPTY_FLAG_BIT = 8;
  localparam int STA_RXISEL_LSB = 6;
  localparam int STA_RECEIVER_IDLE_FLAG_BIT = 4;
  localparam int STA_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int STA_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int STA_RX_DATA_AVAILABLE_FLAG_BIT = 0;
  localparam logic [15:0] STA_WR_MASK = 16'h04c0;
  localparam logic [15:0] STA_RST = 16'h0110;
  localparam logic [15:0] BRG_RST = 16'h0000;
  localparam logic [15:0] RX_RST = 16'h0000;
  // bit timing: sixteen ticks per bit, sample at the middle
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] FIFO_3 = 3'h3;
  localparam logic [2:0] FIFO_4 = 3'h4;
  typedef struct packed {
    logic en;
    logic halt_idle;
    logic wake;
    logic loop;
  } ulp_mode_t;
  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA, PH_STOP} ulp_phase_t;
endpackage

// >>> ulp_remote.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_remote (
  // bit length in clocks
  input  wire logic        clk_in,
  input  wire logic [31:0] bit_len_in,
  // lines
  input  wire logic        rx_in,
  output logic             tx_out
);
  logic [7:0] got_ff;
  logic [7:0] b;
  int         n_got = 0;
  initial tx_out = 1'b1;
  // start, eight bits lsb first, stop; idle high
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      tx_out <= f[i];
      repeat (bit_len_in) @(posedge clk_in);
    end
  endtask
  // sample each bit in its middle
  always
  begin
    @(negedge rx_in);
    repeat (bit_len_in / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_len_in) @(posedge clk_in);
      b[i] = rx_in;
    end
    got_ff = b;
    n_got++;
  end
endmodule
`default_nettype wire

// >>> ulp_uart_lowpower.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_uart_lowpower
  import ulp_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             srst_in,
  // ahb-lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // power state
  input  wire logic             sleep_in,
  input  wire logic             idle_in,
  output logic                  wake_out,
  // serial pins
  input  wire logic [NPORT-1:0] serial_in_pin_in,
  output logic      [NPORT-1:0] serial_out_pin_out,
  // interrupt
  output logic                  irq_out
);
  logic             bus_wr_ff;
  logic [9:0]       bus_idx_ff;
  logic [31:0]      hrdata_ff;
  logic [2*NPORT-1:0] irq_sta_ff;
  logic [2*NPORT-1:0] irq_en_ff;
  logic             wake_ff;
  logic             nxt_bus_wr;
  logic [9:0]       nxt_bus_idx;
  logic [31:0]      nxt_hrdata;
  logic [2*NPORT-1:0] nxt_irq_sta;
  logic [2*NPORT-1:0] nxt_irq_en;
  logic             nxt_wake;
  logic             acc_ok;
  logic             rd_acc;
  logic [9:0]       acc_idx;
  logic [15:0]      wdata;
  logic [NPORT-1:0] ev_rx;
  logic [NPORT-1:0] ev_tx;
  logic [NPORT-1:0] ev_wake;
  logic [15:0]      rd_mode [NPORT];
  logic [15:0]      rd_sta [NPORT];
  logic [15:0]      rd_rx [NPORT];
  logic [15:0]      rd_brg [NPORT];

  assign acc_ok = hsel_in && hready_in && htrans_in[1] && (hsize_in == SIZE_WORD)
                  && (haddr_in[31:12] == 20'h00000) && (haddr_in[1:0] == 2'h0);
  assign rd_acc = acc_ok && !hwrite_in;
  assign acc_idx = haddr_in[11:2];
  assign wdata = hwdata_in[15:0];

  // bus slave, read data registered in the address phase
  always_comb
  begin
    nxt_bus_wr = acc_ok && hwrite_in;
    nxt_bus_idx = acc_idx;
    nxt_hrdata = 32'h00000000;
    if (rd_acc)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (acc_idx == ((p == 0) ? IDX_P1_MODE : IDX_P2_MODE))
          nxt_hrdata = {16'h0000, rd_mode[p]};
        if (acc_idx == ((p == 0) ? IDX_P1_STA : IDX_P2_STA))
          nxt_hrdata = {16'h0000, rd_sta[p]};
        if (acc_idx == ((p == 0) ? IDX_P1_RX : IDX_P2_RX))
          nxt_hrdata = {16'h0000, rd_rx[p]};
        if (acc_idx == ((p == 0) ? IDX_P1_BRG : IDX_P2_BRG))
          nxt_hrdata = {16'h0000, rd_brg[p]};
      end
      if (acc_idx == IDX_IRQ_STATUS)
        nxt_hrdata = {{(32-2*NPORT){1'b0}}, irq_sta_ff};
      if (acc_idx == IDX_IRQ_ENABLE)
        nxt_hrdata = {{(32-2*NPORT){1'b0}}, irq_en_ff};
    end
    // sticky flags, a new event wins over a clear
    nxt_irq_sta = irq_sta_ff;
    if (bus_wr_ff && bus_idx_ff == IDX_IRQ_CLEAR)
      nxt_irq_sta = irq_sta_ff & ~wdata[2*NPORT-1:0];
    nxt_irq_en = irq_en_ff;
    if (bus_wr_ff && bus_idx_ff == IDX_IRQ_ENABLE)
      nxt_irq_en = wdata[2*NPORT-1:0];
    nxt_wake = 1'b0;
    for (int p = 0; p < NPORT; p++)
    begin
      nxt_irq_sta[2*p] = nxt_irq_sta[2*p] | ev_rx[p] | ev_wake[p];
      nxt_irq_sta[2*p+1] = nxt_irq_sta[2*p+1] | ev_tx[p];
      if (ev_wake[p] && irq_en_ff[2*p])
        nxt_wake = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      bus_wr_ff <= 1'b0;
      bus_idx_ff <= 10'h000;
      hrdata_ff <= 32'h00000000;
      irq_sta_ff <= '0;
      irq_en_ff <= '0;
      wake_ff <= 1'b0;
    end
    else
    begin
      bus_wr_ff <= nxt_bus_wr;
      bus_idx_ff <= nxt_bus_idx;
      hrdata_ff <= nxt_hrdata;
      irq_sta_ff <= nxt_irq_sta;
      irq_en_ff <= nxt_irq_en;
      wake_ff <= nxt_wake;
    end
  end

  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign irq_out = |(irq_sta_ff & irq_en_ff);
  assign wake_out = wake_ff;

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    localparam logic [9:0] I_MODE = (p == 0) ? IDX_P1_MODE : IDX_P2_MODE;
    localparam logic [9:0] I_STA = (p == 0) ? IDX_P1_STA : IDX_P2_STA;
    localparam logic [9:0] I_TX = (p == 0) ? IDX_P1_TX : IDX_P2_TX;
    localparam logic [9:0] I_RX = (p == 0) ? IDX_P1_RX : IDX_P2_RX;
    localparam logic [9:0] I_BRG = (p == 0) ? IDX_P1_BRG : IDX_P2_BRG;
    logic [15:0] mode_ff, nxt_mode;
    logic [15:0] ctl_ff, nxt_ctl;
    logic [15:0] brg_ff, nxt_brg;
    logic [15:0] div_ff, nxt_div;
    logic        tick_ff, nxt_tick;
    logic [7:0]  txh_ff, nxt_txh;
    logic        txh_full_ff, nxt_txh_full;
    ulp_phase_t  tx_ph_ff, nxt_tx_ph;
    logic [7:0]  tx_sh_ff, nxt_tx_sh;
    logic [2:0]  tx_bit_ff, nxt_tx_bit;
    logic [3:0]  tx_cnt_ff, nxt_tx_cnt;
    logic        ser_ff, nxt_ser;
    ulp_phase_t  rx_ph_ff, nxt_rx_ph;
    logic [7:0]  rx_sh_ff, nxt_rx_sh;
    logic [2:0]  rx_bit_ff, nxt_rx_bit;
    logic [3:0]  rx_cnt_ff, nxt_rx_cnt;
    logic [8:0]  fifo_ff [RX_DEPTH];
    logic [8:0]  nxt_fifo [RX_DEPTH];
    logic [1:0]  wp_ff, nxt_wp;
    logic [1:0]  rp_ff, nxt_rp;
    logic [2:0]  cnt_ff, nxt_cnt;
    logic        overrun_error_flag_ff, nxt_overrun_error_flag;
    logic        sync1_ff, sync2_ff, prev_ff;
    logic        rx_line;
    logic        fall;
    logic        run;
    logic        pop;
    logic        push;
    logic        tx_load;
    ulp_mode_t   m;

    assign m = '{en: mode_ff[MODE_EN_BIT], halt_idle: mode_ff[MODE_HALT_BIT],
                 wake: mode_ff[MODE_WAKE_BIT], loop: mode_ff[MODE_LOOP_BIT]};
    // clocks stop in sleep, and in idle when halting is selected
    assign run = m.en && !sleep_in && !(idle_in && m.halt_idle);
    assign rx_line = m.loop ? ser_ff : sync2_ff;
    assign fall = prev_ff && !rx_line;
    assign pop = rd_acc && (acc_idx == I_RX) && (cnt_ff != 3'h0);
    // edge watch runs on the free system clock, not the stopped port clock
    assign ev_wake[p] = sleep_in && m.wake && m.en && fall;

    always_comb
    begin
      nxt_mode = mode_ff;
      nxt_ctl = ctl_ff;
      nxt_brg = brg_ff;
      nxt_txh = txh_ff;
      nxt_txh_full = txh_full_ff;
      nxt_overrun_error_flag = overrun_error_flag_ff;
      push = 1'b0;
      tx_load = 1'b0;
      if (bus_wr_ff && bus_idx_ff == I_MODE)
        nxt_mode = wdata & MODE_WR_MASK;
      if (bus_wr_ff && bus_idx_ff == I_STA)
      begin
        nxt_ctl = wdata & STA_WR_MASK;
        if (!wdata[STA_OVERRUN_ERROR_FLAG_BIT])
          nxt_overrun_error_flag = 1'b0;
      end
      if (bus_wr_ff && bus_idx_ff == I_BRG)
        nxt_brg = wdata;
      if (bus_wr_ff && bus_idx_ff == I_TX && !txh_full_ff)
      begin
        nxt_txh = wdata[7:0];
        nxt_txh_full = 1'b1;
      end
      // baud tick every brg+1 cycles, held low while stopped
      nxt_div = 16'h0000;
      nxt_tick = 1'b0;
      if (run)
      begin
        if (div_ff >= brg_ff)
          nxt_tick = 1'b1;
        else
          nxt_div = div_ff + 16'h0001;
      end
      // transmitter
      nxt_tx_ph = tx_ph_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_bit = tx_bit_ff;
      nxt_tx_cnt = tx_cnt_ff;
      if (!run)
        nxt_tx_ph = PH_IDLE;
      else if (tx_ph_ff == PH_IDLE)
      begin
        if (ctl_ff[STA_TXEN_BIT] && txh_full_ff && tick_ff)
        begin
          tx_load = 1'b1;
          nxt_tx_sh = txh_ff;
          nxt_txh_full = 1'b0;
          nxt_tx_ph = PH_START;
          nxt_tx_cnt = 4'h0;
          nxt_tx_bit = 3'h0;
        end
      end
      else if (tick_ff)
      begin
        nxt_tx_cnt = tx_cnt_ff + 4'h1;
        if (tx_cnt_ff == TICK_LAST)
        begin
          case (tx_ph_ff)
            PH_START: nxt_tx_ph = PH_DATA;
            PH_DATA:
            begin
              nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
              nxt_tx_bit = tx_bit_ff + 3'h1;
              if (tx_bit_ff == BIT_LAST)
                nxt_tx_ph = PH_STOP;
            end
            default: nxt_tx_ph = PH_IDLE;
          endcase
        end
      end
      nxt_ser = 1'b1;
      if (run && tx_ph_ff == PH_START)
        nxt_ser = 1'b0;
      else if (run && tx_ph_ff == PH_DATA)
        nxt_ser = tx_sh_ff[0];
      // receiver
      nxt_rx_ph = rx_ph_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_cnt = rx_cnt_ff;
      if (!run)
        nxt_rx_ph = PH_IDLE;
      else if (rx_ph_ff == PH_IDLE)
      begin
        if (!rx_line)
        begin
          nxt_rx_ph = PH_START;
          nxt_rx_cnt = 4'h0;
          nxt_rx_bit = 3'h0;
        end
      end
      else if (tick_ff)
      begin
        nxt_rx_cnt = rx_cnt_ff + 4'h1;
        case (rx_ph_ff)
          PH_START:
          begin
            if (rx_cnt_ff == TICK_HALF)
            begin
              nxt_rx_cnt = 4'h0;
              nxt_rx_ph = rx_line ? PH_IDLE : PH_DATA;
            end
          end
          PH_DATA:
          begin
            if (rx_cnt_ff == TICK_LAST)
            begin
              nxt_rx_sh = {rx_line, rx_sh_ff[7:1]};
              nxt_rx_bit = rx_bit_ff + 3'h1;
              if (rx_bit_ff == BIT_LAST)
                nxt_rx_ph = PH_STOP;
            end
          end
          default:
          begin
            if (rx_cnt_ff == TICK_LAST)
            begin
              nxt_rx_ph = PH_IDLE;
              if (cnt_ff == FIFO_4)
                nxt_overrun_error_flag = 1'b1;
              else if (!overrun_error_flag_ff)
                push = 1'b1;
            end
          end
        endcase
      end
      // fifo keeps its words through sleep, only reset clears it
      nxt_fifo = fifo_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      if (push)
      begin
        nxt_fifo[wp_ff] = {!rx_line, rx_sh_ff};
        nxt_wp = wp_ff + 2'h1;
      end
      if (pop)
        nxt_rp = rp_ff + 2'h1;
      nxt_cnt = cnt_ff + {2'h0, push} - {2'h0, pop};
    end

    // selection applies to normal reception only
    always_comb
    begin
      case (ctl_ff[STA_RXISEL_LSB+1:STA_RXISEL_LSB])
        2'h2: ev_rx[p] = push && (nxt_cnt == FIFO_3);
        2'h3: ev_rx[p] = push && (nxt_cnt == FIFO_4);
        default: ev_rx[p] = push;
      endcase
    end

    assign ev_tx[p] = tx_load;
    assign rd_mode[p] = mode_ff;
    assign rd_sta[p] = ctl_ff | {5'h00, 1'b0, txh_full_ff, tx_ph_ff == PH_IDLE,
                                 2'h0, 1'b0, rx_ph_ff == PH_IDLE, 1'b0,
                                 fifo_ff[rp_ff][8], overrun_error_flag_ff, cnt_ff != 3'h0};
    assign rd_rx[p] = {8'h00, fifo_ff[rp_ff][7:0]};
    assign rd_brg[p] = brg_ff;
    assign serial_out_pin_out[p] = ser_ff;

    always_ff @(posedge clk_sys_in)
    begin
      if (srst_in)
      begin
        mode_ff <= MODE_RST;
        ctl_ff <= STA_RST & STA_WR_MASK;
        brg_ff <= BRG_RST;
        div_ff <= 16'h0000;
        tick_ff <= 1'b0;
        txh_ff <= 8'h00;
        txh_full_ff <= 1'b0;
        tx_ph_ff <= PH_IDLE;
        tx_sh_ff <= 8'h00;
        tx_bit_ff <= 3'h0;
        tx_cnt_ff <= 4'h0;
        ser_ff <= 1'b1;
        rx_ph_ff <= PH_IDLE;
        rx_sh_ff <= 8'h00;
        rx_bit_ff <= 3'h0;
        rx_cnt_ff <= 4'h0;
        for (int i = 0; i < RX_DEPTH; i++)
          fifo_ff[i] <= RX_RST[8:0];
        wp_ff <= 2'h0;
        rp_ff <= 2'h0;
        cnt_ff <= 3'h0;
        overrun_error_flag_ff <= 1'b0;
        sync1_ff <= 1'b1;
        sync2_ff <= 1'b1;
        prev_ff <= 1'b1;
      end
      else
      begin
        mode_ff <= nxt_mode;
        ctl_ff <= nxt_ctl;
        brg_ff <= nxt_brg;
        div_ff <= nxt_div;
        tick_ff <= nxt_tick;
        txh_ff <= nxt_txh;
        txh_full_ff <= nxt_txh_full;
        tx_ph_ff <= nxt_tx_ph;
        tx_sh_ff <= nxt_tx_sh;
        tx_bit_ff <= nxt_tx_bit;
        tx_cnt_ff <= nxt_tx_cnt;
        ser_ff <= nxt_ser;
        rx_ph_ff <= nxt_rx_ph;
        rx_sh_ff <= nxt_rx_sh;
        rx_bit_ff <= nxt_rx_bit;
        rx_cnt_ff <= nxt_rx_cnt;
        fifo_ff <= nxt_fifo;
        wp_ff <= nxt_wp;
        rp_ff <= nxt_rp;
        cnt_ff <= nxt_cnt;
        overrun_error_flag_ff <= nxt_overrun_error_flag;
        sync1_ff <= serial_in_pin_in[p];
        sync2_ff <= sync1_ff;
        prev_ff <= rx_line;
      end
    end
  end
endmodule
`default_nettype wire

// >>> ulp_uart_lowpower_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_uart_lowpower_bench
  import ulp_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = SIZE_WORD;
  logic [31:0] blen = 32'd32;
  logic        sleep = 1'b0;
  logic        idle = 1'b0;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        wake;
  logic        irq;
  logic [1:0]  sin;
  logic [1:0]  sout;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] a;
  logic [31:0] seed = 32'h9;
  logic [7:0]  b [4];
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_wake = 0;
  int          n0;
  int          w0;
  always #4 clk = ~clk;
  ulp_uart_lowpower i_ulp_uart_lowpower (
    .clk_sys_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
    .sleep_in(sleep), .idle_in(idle), .wake_out(wake), .serial_in_pin_in(sin),
    .serial_out_pin_out(sout), .irq_out(irq)
  );
  ulp_remote i_ulp_remote_a (
    .clk_in(clk), .bit_len_in(blen), .rx_in(sout[0]), .tx_out(sin[0])
  );
  ulp_remote i_ulp_remote_b (
    .clk_in(clk), .bit_len_in(blen), .rx_in(sout[1]), .tx_out(sin[1])
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] rst_val(input int i);
    return (i < 10 && i % 5 == 1) ? {16'h0, STA_RST} : 32'h0;
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= ad;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1)
      @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1)
      @(posedge clk);
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask
  task automatic rdc(input logic [31:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_n(input int n);
    for (int i = 0; i < 1000 && i_ulp_remote_a.n_got < n; i++)
      @(posedge clk);
    chk(i_ulp_remote_a.n_got, n);
  endtask
  task automatic quiet(input int n);
    int l = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (sout[0] !== 1'b1)
        l++;
    end
    chk(l, 0);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (wake === 1'b1)
      n_wake++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 14; i++)
      rdc(32'h830 + 8 * i, rst_val(i));
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      a = 32'h850 + 40 * (i % 2);
      wr(a, r);
      rdc(a, {16'h0, r[15:0]});
      wr(a - 32, r);
      rdc(a - 32, {16'h0, r[15:0] & MODE_WR_MASK});
    end
    wr(32'h850, 32'h1);
    // a byte-size write is refused
    hsize <= 3'h0;
    wr(32'h850, 32'h7);
    hsize <= SIZE_WORD;
    rdc(32'h850, 32'h1);
    wr(32'h878, 32'h1);
    wr(32'h830, 32'h8000);
    wr(32'h858, 32'h8000);
    wr(32'h838, 32'h0400);
    wr(32'h890, 32'hf);
    wr(32'h888, 32'hf);
    i_ulp_remote_b.send_byte(8'h5a);
    rdc(32'h870, 32'h5a);
    r = xs();
    n0 = i_ulp_remote_a.n_got;
    wr(32'h840, {24'h0, r[7:0]});
    wait_n(n0 + 1);
    chk(i_ulp_remote_a.got_ff, r[7:0]);
    // interrupt raised, masked, cleared
    rdc(32'h880, 32'h6);
    wr(32'h890, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(32'h890, 32'hf);
    chk({31'h0, irq}, 32'h1);
    wr(32'h888, 32'hf);
    rdc(32'h880, 32'h0);
    // fill the receive fifo, flag only when it holds four
    wr(32'h838, 32'h04c0);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      b[i] = r[7:0];
      i_ulp_remote_a.send_byte(b[i]);
      if (i > 1)
        rdc(32'h880, i - 2);
    end
    sleep <= 1'b1;
    repeat (200) @(posedge clk);
    sleep <= 1'b0;
    @(posedge clk);
    rdc(32'h850, 32'h1);
    rdc(32'h830, 32'h8000);
    rdc(32'h838, 32'h05d1);
    for (int i = 0; i < 4; i++)
      rdc(32'h848, {24'h0, b[i]});
    // sleep in mid-frame both ways
    fork
      i_ulp_remote_a.send_byte(8'h55);
    join_none
    wr(32'h840, 32'haa);
    repeat (90) @(posedge clk);
    sleep <= 1'b1;
    repeat (400) @(posedge clk);
    sleep <= 1'b0;
    quiet(400);
    rdc(32'h838, 32'h05d0);
    // wake: enabled, rx irq disabled, port disabled
    for (int k = 0; k < 3; k++)
    begin
      wr(32'h888, 32'hf);
      wr(32'h890, (k == 1) ? 32'he : 32'hf);
      wr(32'h830, (k == 2) ? 32'h0080 : 32'h8080);
      w0 = n_wake;
      sleep <= 1'b1;
      @(posedge clk);
      i_ulp_remote_a.send_byte(8'h00);
      sleep <= 1'b0;
      @(posedge clk);
      chk(n_wake - w0, k == 0);
      rdc(32'h880, k != 2);
    end
    wr(32'h830, 32'h8000);
    idle <= 1'b1;
    n0 = i_ulp_remote_a.n_got;
    wr(32'h840, 32'h3c);
    wait_n(n0 + 1);
    chk(i_ulp_remote_a.got_ff, 32'h3c);
    wr(32'h830, 32'ha000);
    wr(32'h840, 32'hc3);
    quiet(400);
    idle <= 1'b0;
    final_report();
  end
endmodule
`default_nettype wire

// >>> ulp_uart_lowpower_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ulp_checker
  import ulp_pkg::*;
(
  // clock, reset, bus
  input wire logic             clk_sys_in,
  input wire logic             srst_in,
  input wire logic             hsel_in,
  input wire logic [31:0]      haddr_in,
  input wire logic [1:0]       htrans_in,
  input wire logic             hwrite_in,
  input wire logic [2:0]       hsize_in,
  input wire logic [31:0]      hwdata_in,
  input wire logic [31:0]      hrdata_out,
  // power, pins, interrupt
  input wire logic             sleep_in,
  input wire logic             idle_in,
  input wire logic             wake_out,
  input wire logic [NPORT-1:0] serial_out_pin_out,
  input wire logic             irq_out
);
  logic        aw_ff;
  logic [15:0] brg_ff;
  logic [31:0] run_ff;
  // track port one divisor and the length of each line level
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      aw_ff  <= 1'b0;
      brg_ff <= 16'h0;
      run_ff <= 32'h0;
    end
    else
    begin
      aw_ff  <= hsel_in && htrans_in[1] && hwrite_in && haddr_in == 32'h850
                && hsize_in == SIZE_WORD;
      if (aw_ff)
        brg_ff <= hwdata_in[15:0];
      run_ff <= $changed(serial_out_pin_out[0]) ? 32'h1 : run_ff + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  property p_sleep_high;
    disable iff (srst_in) sleep_in [*3] |-> &serial_out_pin_out;
  endproperty
  a_sleep_high: assert property (p_sleep_high)
    else $error("serial line not idle in sleep");
  property p_upper_zero;
    disable iff (srst_in) hrdata_out[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  property p_read_idle;
    disable iff (srst_in) !$past(hsel_in && htrans_in[1] && !hwrite_in) |-> hrdata_out == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data without a read");
  property p_wake_irq;
    disable iff (srst_in) wake_out |-> irq_out;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake without enabled interrupt");
  property p_wake_sleep;
    disable iff (srst_in) wake_out |-> $past(sleep_in);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("wake outside sleep");
  property p_wake_once;
    disable iff (srst_in) wake_out |=> !wake_out;
  endproperty
  a_wake_once: assert property (p_wake_once)
    else $error("wake pulse too long");
  property p_reset;
    srst_in |=> hrdata_out == 32'h0 && !irq_out && !wake_out && &serial_out_pin_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset values");
  property p_bit_time;
    disable iff (srst_in) $rose(serial_out_pin_out[0]) && !sleep_in && !idle_in
      |-> run_ff % ((brg_ff + 32'h1) * 32'h10) == 32'h0;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("bit time off");
  c_wake: cover property (wake_out);
  c_bit: cover property ($rose(serial_out_pin_out[0]) && !sleep_in);
  c_sleep: cover property (sleep_in [*3]);
  c_irq: cover property (irq_out);
endmodule
bind ulp_uart_lowpower ulp_checker i_ulp_checker (
  .clk_sys_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
  .hrdata_out, .sleep_in, .idle_in, .wake_out, .serial_out_pin_out, .irq_out
);
`default_nettype wire
